// ### disc_ctrl_status_word.sv
// Disc controller programmed data path, status word and service interrupt
`timescale 1ns/1ps
`default_nettype none
module disc_ctrl_status_word (
  input wire logic mclk,
  input wire logic rst_n,
  // Host instruction port
  input wire logic ioStrobe,
  input wire logic [1:0] ioFunc,
  input wire logic [15:0] hostWord,
  output logic [15:0] hostReply,
  output logic hostReplyValid,
  output logic siRequest,
  // Sequencer side
  input wire logic dmpMode,
  input wire logic seqBusy,
  input wire logic seqTake,
  input wire logic seqPut,
  input wire logic [15:0] seqWord,
  output logic [15:0] wrWord,
  output logic wrValid,
  output logic cmdPulse,
  output logic [15:0] cmdWord,
  output logic xferEnable,
  output logic writeEnable,
  output logic xferStop,
  output logic zeroFill,
  // Drive and read-back events
  input wire logic driveInop,
  input wire logic driveSeeking,
  input wire logic writeProtect,
  input wire logic crcErr,
  input wire logic parityErr,
  input wire logic seekFail,
  input wire logic headerMismatch,
  input wire logic recordEnd,
  input wire logic recordEod,
  input wire logic recordEof,
  input wire logic recordEor,
  input wire logic scanSeekDone,
  input wire logic restoreDone
);
  // ---------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------
  logic rstMeta_r;
  logic rstSync_r;

  // Async assert, two-flop release so no flop leaves reset mid-edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // ---------------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------------
  flag_link_if fl ();
  buf_link_if bl ();

  sticky_flags u_flags (
    .clk(mclk),
    .rstN(rstSync_r),
    .lnk(fl.owner)
  );

  pio_word_buffer u_buf (
    .clk(mclk),
    .rstN(rstSync_r),
    .lnk(bl.owner)
  );

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  disc_pkg::xfer_type xfer_r;
  disc_pkg::xfer_type xfer_nxt;
  logic [15:0] reply_r;
  logic replyValid_r;
  logic siReq_r;
  logic siConn_r;
  logic [1:0] unit_r;
  logic busy_r;
  logic inopPrev_r;
  logic cmdPulse_r;
  logic [15:0] cmdWord_r;
  logic xferEnable_r;
  logic writeEnable_r;
  logic xferStop_r;
  logic zeroFill_r;

  // ---------------------------------------------------------------------
  // Instruction decode
  // ---------------------------------------------------------------------
  wire disc_pkg::cmd_type kind = disc_pkg::decode_cmd(hostWord);
  wire isCmd = ioStrobe && (ioFunc == disc_pkg::FN_OUT_CMD);
  wire isOutData = ioStrobe && (ioFunc == disc_pkg::FN_OUT_DATA);
  wire isInData = ioStrobe && (ioFunc == disc_pkg::FN_IN_DATA);
  wire isInStatus = ioStrobe && (ioFunc == disc_pkg::FN_IN_STATUS);
  // While busy only terminate and idle commands get through
  wire cmdTermOrIdle = (kind == disc_pkg::CMD_TERM) || (kind == disc_pkg::CMD_IDLE);
  wire cmdAccept = isCmd && (!busy_r || cmdTermOrIdle);
  wire acceptRead = cmdAccept && (kind == disc_pkg::CMD_READ);
  wire acceptWrite = cmdAccept && (kind == disc_pkg::CMD_WRITE);
  wire acceptCyl = cmdAccept && (kind == disc_pkg::CMD_CYLSEL);
  wire acceptSel = cmdAccept && (kind == disc_pkg::CMD_SELECT);
  wire acceptTerm = cmdAccept && (kind == disc_pkg::CMD_TERM);
  // Cylinder select, read, write and idle carry the SI connect bit
  wire carriesSi = cmdAccept && !acceptSel && !acceptTerm;
  wire [7:0] cylAddr = hostWord[7:0];
  wire cylBad = (cylAddr > disc_pkg::CYL_MAX) && (cylAddr != disc_pkg::CYL_RESTORE);

  // Data words move by instruction only outside memory-processor mode
  assign bl.hostLoad = isOutData && !dmpMode;
  assign bl.hostTake = isInData && !dmpMode;
  assign bl.hostWord = hostWord;
  assign bl.seqTake = seqTake;
  assign bl.seqPut = seqPut;
  assign bl.seqWord = seqWord;

  // ---------------------------------------------------------------------
  // Flag events
  // ---------------------------------------------------------------------
  wire [disc_pkg::NFLAG-1:0] f = fl.flags;
  wire inWrite = (xfer_r == disc_pkg::XF_WRITE);
  wire inRead = (xfer_r == disc_pkg::XF_READ);
  wire paceMiss = (inWrite && bl.underRun) || (inRead && bl.overRun);
  wire readEor = inRead && recordEnd && recordEor;
  wire seekErrSet = (acceptCyl && cylBad) || seekFail || headerMismatch;
  wire wloSet = acceptWrite && writeProtect;
  wire inopNow = driveInop && !driveSeeking;
  wire busyFall = busy_r && !seqBusy;
  wire inopRise = inopNow && !inopPrev_r && busy_r;
  wire siEvent = busyFall || inopRise || scanSeekDone;

  // Set terms, one per sticky flag
  assign fl.setVec[disc_pkg::F_UFO] = paceMiss;
  assign fl.setVec[disc_pkg::F_CRC] = inRead && crcErr;
  assign fl.setVec[disc_pkg::F_MPE] = dmpMode && parityErr;
  assign fl.setVec[disc_pkg::F_WLO] = wloSet;
  assign fl.setVec[disc_pkg::F_SKE] = seekErrSet;
  assign fl.setVec[disc_pkg::F_EOD] = inRead && recordEnd && recordEod;
  assign fl.setVec[disc_pkg::F_EOF] = inRead && recordEnd && recordEof;
  assign fl.setVec[disc_pkg::F_EOR] = readEor;
  assign fl.setVec[disc_pkg::F_SKC] = scanSeekDone && siConn_r;

  // New command wipes the resettable flags; seek error waits for restore
  assign fl.clrVec = (cmdAccept ? ~disc_pkg::KEEP_MASK : disc_pkg::FLAG_RESET)
                   | (restoreDone ? disc_pkg::KEEP_MASK : disc_pkg::FLAG_RESET);

  // ---------------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------------
  logic [15:0] status;
  wire errAny = f[disc_pkg::F_UFO] | f[disc_pkg::F_CRC] | inopNow | f[disc_pkg::F_MPE]
              | f[disc_pkg::F_WLO] | f[disc_pkg::F_SKE];
  wire bufReady = (inRead && bl.rdFull) || (inWrite && !bl.wrFull);

  // Bit 0 lands in the top position so the host sees bit order directly
  assign status[disc_pkg::SB_ERR] = ~errAny;
  assign status[disc_pkg::SB_UFO] = f[disc_pkg::F_UFO];
  assign status[disc_pkg::SB_CRC] = f[disc_pkg::F_CRC];
  assign status[disc_pkg::SB_INOP] = inopNow;
  assign status[disc_pkg::SB_MPE] = f[disc_pkg::F_MPE];
  // Plain protection shows here without pulling the error summary low
  assign status[disc_pkg::SB_WLO] = writeProtect | f[disc_pkg::F_WLO];
  assign status[disc_pkg::SB_SKE] = f[disc_pkg::F_SKE];
  assign status[disc_pkg::SB_BUSY] = busy_r;
  assign status[disc_pkg::SB_RDY_N] = ~bufReady;
  assign status[disc_pkg::SB_EOD] = f[disc_pkg::F_EOD];
  assign status[disc_pkg::SB_EOF] = f[disc_pkg::F_EOF];
  assign status[disc_pkg::SB_EOR] = f[disc_pkg::F_EOR];
  assign status[disc_pkg::SB_SEEK] = driveSeeking;
  assign status[disc_pkg::SB_SKC] = f[disc_pkg::F_SKC];
  assign status[1:0] = unit_r;

  // ---------------------------------------------------------------------
  // Transfer state
  // ---------------------------------------------------------------------
  // Any stopping error parks the transfer; terminate or busy falling ends it
  always_comb begin
    xfer_nxt = xfer_r;
    case (xfer_r)
      disc_pkg::XF_IDLE: begin
        if (acceptRead && !f[disc_pkg::F_SKE]) xfer_nxt = disc_pkg::XF_READ;
        else if (acceptWrite && !writeProtect && !f[disc_pkg::F_SKE]) xfer_nxt = disc_pkg::XF_WRITE;
      end
      disc_pkg::XF_READ: begin
        if (paceMiss || crcErr || readEor || seekErrSet) begin
          xfer_nxt = disc_pkg::XF_HALT;
        end
      end
      disc_pkg::XF_WRITE: begin
        if (paceMiss) xfer_nxt = disc_pkg::XF_FILL;
        else if (seekErrSet) xfer_nxt = disc_pkg::XF_HALT;
      end
      disc_pkg::XF_HALT, disc_pkg::XF_FILL: begin
        xfer_nxt = xfer_r;
      end
      default: begin
        xfer_nxt = disc_pkg::XF_IDLE;
      end
    endcase
    if (acceptTerm || busyFall) xfer_nxt = disc_pkg::XF_IDLE;
  end

  always_ff @(posedge mclk or negedge rstSync_r) begin
    if (!rstSync_r) xfer_r <= disc_pkg::XF_IDLE;
    else xfer_r <= xfer_nxt;
  end

  // ---------------------------------------------------------------------
  // Sequencer controls
  // ---------------------------------------------------------------------
  // Seek error shuts both the data path and the write gate
  always_ff @(posedge mclk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      xferEnable_r <= 1'b0;
      writeEnable_r <= 1'b0;
      xferStop_r <= 1'b0;
      zeroFill_r <= 1'b0;
    end else begin
      xferEnable_r <= (xfer_nxt == disc_pkg::XF_READ || xfer_nxt == disc_pkg::XF_WRITE)
                      && !f[disc_pkg::F_SKE];
      writeEnable_r <= (xfer_nxt == disc_pkg::XF_WRITE) && !f[disc_pkg::F_SKE];
      xferStop_r <= (xfer_nxt == disc_pkg::XF_HALT) || (xfer_nxt == disc_pkg::XF_FILL);
      zeroFill_r <= (xfer_nxt == disc_pkg::XF_FILL);
    end
  end

  // Command word handed on unchanged for the sequencer to execute
  always_ff @(posedge mclk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      cmdPulse_r <= 1'b0;
      cmdWord_r <= disc_pkg::WORD_RESET;
    end else begin
      cmdPulse_r <= cmdAccept;
      if (cmdAccept) cmdWord_r <= hostWord;
    end
  end

  // ---------------------------------------------------------------------
  // Busy, selection and service interrupt
  // ---------------------------------------------------------------------
  // Busy follows the sequencer, which never goes busy on drive select
  always_ff @(posedge mclk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      busy_r <= 1'b0;
      inopPrev_r <= 1'b0;
    end else begin
      busy_r <= seqBusy;
      inopPrev_r <= inopNow;
    end
  end

  // Connect state and selected unit change only on an accepted command
  always_ff @(posedge mclk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      siConn_r <= 1'b0;
      unit_r <= disc_pkg::UNIT_RESET;
    end else begin
      if (carriesSi) siConn_r <= hostWord[disc_pkg::CB_SI];
      if (acceptSel) unit_r <= hostWord[1:0];
    end
  end

  // Unconnected interrupts are dropped; scan seek done is not flagged in status either
  always_ff @(posedge mclk or negedge rstSync_r) begin
    if (!rstSync_r) siReq_r <= 1'b0;
    else siReq_r <= siEvent && siConn_r;
  end

  // ---------------------------------------------------------------------
  // Host reply
  // ---------------------------------------------------------------------
  // Reply one cycle after the instruction; no reply on memory-processor data
  always_ff @(posedge mclk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      reply_r <= disc_pkg::WORD_RESET;
      replyValid_r <= 1'b0;
    end else begin
      replyValid_r <= isInStatus || bl.hostTake;
      if (isInStatus) reply_r <= status;
      else if (bl.hostTake) reply_r <= bl.rdWord;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign hostReply = reply_r;
  assign hostReplyValid = replyValid_r;
  assign siRequest = siReq_r;
  assign wrWord = bl.wrWord;
  assign wrValid = bl.wrFull;
  assign cmdPulse = cmdPulse_r;
  assign cmdWord = cmdWord_r;
  assign xferEnable = xferEnable_r;
  assign writeEnable = writeEnable_r;
  assign xferStop = xferStop_r;
  assign zeroFill = zeroFill_r;
endmodule : disc_ctrl_status_word
`default_nettype wire

// ### disc_pkg.sv
// Shared constants, types and decoding for the disc status and data path
`default_nettype none
package disc_pkg;
  // -------------------------------------------------------------------
  // Widths and sticky flag slots
  // -------------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int NFLAG = 9;
  localparam int F_UFO = 0;
  localparam int F_CRC = 1;
  localparam int F_MPE = 2;
  localparam int F_WLO = 3;
  localparam int F_SKE = 4;
  localparam int F_EOD = 5;
  localparam int F_EOF = 6;
  localparam int F_EOR = 7;
  localparam int F_SKC = 8;
  // Flags that survive command acceptance (seek error only)
  localparam logic [NFLAG-1:0] KEEP_MASK = 9'h010;
  localparam logic [NFLAG-1:0] FLAG_RESET = 9'h000;
  // -------------------------------------------------------------------
  // Status word positions: status bit n sits at word position 15-n
  // -------------------------------------------------------------------
  localparam int SB_ERR = 15;
  localparam int SB_UFO = 14;
  localparam int SB_CRC = 13;
  localparam int SB_INOP = 12;
  localparam int SB_MPE = 11;
  localparam int SB_WLO = 10;
  localparam int SB_SKE = 9;
  localparam int SB_BUSY = 8;
  localparam int SB_RDY_N = 7;
  localparam int SB_EOD = 6;
  localparam int SB_EOF = 5;
  localparam int SB_EOR = 4;
  localparam int SB_SEEK = 3;
  localparam int SB_SKC = 2;
  // -------------------------------------------------------------------
  // Command word fields and codes
  // -------------------------------------------------------------------
  localparam int CB_RW = 15;
  localparam int CB_CTL = 14;
  localparam int CB_SI = 12;
  localparam int CB_DIR = 11;
  localparam logic [7:0] CYL_MAX = 8'hCA;
  localparam logic [7:0] CYL_RESTORE = 8'hFF;
  localparam logic [1:0] FN_OUT_DATA = 2'h0;
  localparam logic [1:0] FN_IN_DATA = 2'h1;
  localparam logic [1:0] FN_IN_STATUS = 2'h2;
  localparam logic [1:0] FN_OUT_CMD = 2'h3;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [1:0] UNIT_RESET = 2'h0;

  typedef enum logic [2:0] {
    CMD_WRITE, CMD_READ, CMD_CYLSEL, CMD_TERM, CMD_IDLE, CMD_SELECT
  } cmd_type;

  typedef enum logic [2:0] {XF_IDLE, XF_READ, XF_WRITE, XF_HALT, XF_FILL} xfer_type;

  // Command kind from the top bits of an output command word
  function automatic cmd_type decode_cmd(input logic [15:0] w);
    cmd_type k;
    k = CMD_IDLE;
    if (w[CB_RW]) begin
      k = w[CB_DIR] ? CMD_READ : CMD_WRITE;
    end else if (!w[CB_CTL]) begin
      k = CMD_SELECT;
    end else if (w[11:9] == 3'h1) begin
      k = CMD_CYLSEL;
    end else if (w[11] || w[10]) begin
      k = CMD_TERM;
    end
    return k;
  endfunction : decode_cmd
endpackage : disc_pkg
`default_nettype wire

// ### disc_links_if.sv
// Interfaces joining the status block to its flag bank and word buffer
`timescale 1ns/1ps
`default_nettype none
interface flag_link_if;
  logic [disc_pkg::NFLAG-1:0] setVec;
  logic [disc_pkg::NFLAG-1:0] clrVec;
  logic [disc_pkg::NFLAG-1:0] flags;
  modport owner(input setVec, input clrVec, output flags);
  modport user(output setVec, output clrVec, input flags);
endinterface : flag_link_if

interface buf_link_if;
  logic hostLoad;
  logic hostTake;
  logic seqTake;
  logic seqPut;
  logic [15:0] hostWord;
  logic [15:0] seqWord;
  logic [15:0] wrWord;
  logic [15:0] rdWord;
  logic wrFull;
  logic rdFull;
  logic underRun;
  logic overRun;
  modport owner(input hostLoad, hostTake, seqTake, seqPut, hostWord, seqWord,
                output wrWord, rdWord, wrFull, rdFull, underRun, overRun);
  modport user(output hostLoad, hostTake, seqTake, seqPut, hostWord, seqWord,
               input wrWord, rdWord, wrFull, rdFull, underRun, overRun);
endinterface : buf_link_if
`default_nettype wire

// ### sticky_flags.sv
// Bank of sticky status flags where a set beats a clear
`timescale 1ns/1ps
`default_nettype none
module sticky_flags (
  input wire logic clk,
  input wire logic rstN,
  flag_link_if.owner lnk
);
  logic [disc_pkg::NFLAG-1:0] flag_r;
  logic [disc_pkg::NFLAG-1:0] flag_nxt;

  // Set wins so an event landing on the clearing command is kept
  genvar i;
  generate
    for (i = 0; i < disc_pkg::NFLAG; i++) begin : g_flag
      assign flag_nxt[i] = lnk.setVec[i] | (flag_r[i] & ~lnk.clrVec[i]);
    end
  endgenerate

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) flag_r <= disc_pkg::FLAG_RESET;
    else flag_r <= flag_nxt;
  end

  assign lnk.flags = flag_r;
endmodule : sticky_flags
`default_nettype wire

// ### pio_word_buffer.sv
// One-word holding registers for programmed writes and reads
`timescale 1ns/1ps
`default_nettype none
module pio_word_buffer (
  input wire logic clk,
  input wire logic rstN,
  buf_link_if.owner lnk
);
  logic [15:0] wrWord_r;
  logic [15:0] rdWord_r;
  logic wrFull_r;
  logic rdFull_r;
  logic underRun_r;
  logic overRun_r;

  // Host fills the write word, sequencer drains it; the reverse on reads
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrWord_r <= disc_pkg::WORD_RESET;
      rdWord_r <= disc_pkg::WORD_RESET;
      wrFull_r <= 1'b0;
      rdFull_r <= 1'b0;
      underRun_r <= 1'b0;
      overRun_r <= 1'b0;
    end else begin
      if (lnk.hostLoad) wrWord_r <= lnk.hostWord;
      if (lnk.seqPut) rdWord_r <= lnk.seqWord;
      wrFull_r <= lnk.hostLoad | (wrFull_r & ~lnk.seqTake);
      rdFull_r <= lnk.seqPut | (rdFull_r & ~lnk.hostTake);
      // Host missed the pace: take from empty, or put over unread word
      underRun_r <= lnk.seqTake & ~wrFull_r;
      overRun_r <= lnk.seqPut & rdFull_r & ~lnk.hostTake;
    end
  end

  assign lnk.wrWord = wrWord_r;
  assign lnk.rdWord = rdWord_r;
  assign lnk.wrFull = wrFull_r;
  assign lnk.rdFull = rdFull_r;
  assign lnk.underRun = underRun_r;
  assign lnk.overRun = overRun_r;
endmodule : pio_word_buffer
`default_nettype wire

// ### disc_ctrl_status_word_properties.sv
// Port-level assertions for the disc status word block
`timescale 1ns/1ps
`default_nettype none
module disc_status_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ioStrobe,
  input wire logic [1:0] ioFunc,
  input wire logic [15:0] hostWord,
  input wire logic [15:0] hostReply,
  input wire logic hostReplyValid,
  input wire logic siRequest,
  input wire logic dmpMode,
  input wire logic seqBusy,
  input wire logic seqTake,
  input wire logic [15:0] wrWord,
  input wire logic wrValid,
  input wire logic cmdPulse,
  input wire logic [15:0] cmdWord
);
  // -------------------------------------------------------------------
  // Host instruction answers
  // -------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_status_answer: assert property (ioStrobe && ioFunc == disc_pkg::FN_IN_STATUS |=> hostReplyValid)
    else $error("status read not answered");
  a_data_answer: assert property (ioStrobe && ioFunc == disc_pkg::FN_IN_DATA && !dmpMode
    |=> hostReplyValid)
    else $error("data read not answered");
  a_dmp_refuse: assert property (ioStrobe && ioFunc == disc_pkg::FN_IN_DATA && dmpMode
    |=> !hostReplyValid)
    else $error("data read answered during memory transfer");
  a_data_load: assert property (ioStrobe && ioFunc == disc_pkg::FN_OUT_DATA && !dmpMode && !seqTake
    |=> wrValid && wrWord == $past(hostWord))
    else $error("output data word not held");
  // Summary error is active low; protect alone must not pull it
  a_error_summary: assert property (hostReplyValid && $past(ioFunc) == disc_pkg::FN_IN_STATUS
    && (|hostReply[14:11] || hostReply[9]) |-> !hostReply[15])
    else $error("error summary bit not low");
  a_cmd_accept: assert property (ioStrobe && ioFunc == disc_pkg::FN_OUT_CMD && !seqBusy
    && !$past(seqBusy) |=> cmdPulse && cmdWord == $past(hostWord))
    else $error("idle controller did not accept command");
  a_busy_refuse: assert property (ioStrobe && ioFunc == disc_pkg::FN_OUT_CMD && hostWord[15]
    && seqBusy && $past(seqBusy) |=> !cmdPulse)
    else $error("transfer command accepted while busy");
  a_si_single: assert property (siRequest |=> !siRequest)
    else $error("service interrupt longer than one cycle");
endmodule : disc_status_checker
bind disc_ctrl_status_word disc_status_checker u_disc_status_checker (.mclk(mclk), .rst_n(rst_n),
  .ioStrobe(ioStrobe), .ioFunc(ioFunc), .hostWord(hostWord), .hostReply(hostReply),
  .hostReplyValid(hostReplyValid), .siRequest(siRequest), .dmpMode(dmpMode), .seqBusy(seqBusy),
  .seqTake(seqTake), .wrWord(wrWord), .wrValid(wrValid), .cmdPulse(cmdPulse), .cmdWord(cmdWord));
`default_nettype wire

// ### host_port_model.sv
// Host computer side that issues single I/O instructions
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  input wire logic mclk,
  output logic ioStrobe,
  output logic [1:0] ioFunc,
  output logic [15:0] hostWord
);
  initial begin
    ioStrobe = 1'b0;
    ioFunc = 2'h0;
    hostWord = 16'h0000;
  end
  // One instruction per call; word lines scramble once released
  task automatic issue(input logic [1:0] func, input logic [15:0] word);
    @(posedge mclk);
    ioStrobe <= 1'b1;
    ioFunc <= func;
    hostWord <= word;
    @(posedge mclk);
    ioStrobe <= 1'b0;
    hostWord <= ~word;
  endtask : issue
endmodule : host_port_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the disc status word and data path
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [15:0] MSK = 16'hFF7C;
  localparam logic [15:0] IDLE = 16'h4000;
  localparam logic [15:0] CYL = 16'h4200;
  logic mclk = 1'b0, rstN = 1'b0, ioStrobe, hostReplyValid, siRequest, wrValid;
  logic dmpMode = 0, seqBusy = 0, seqPut = 0, driveInop = 0, driveSeeking = 0, writeProtect = 0;
  logic recordEnd = 0, recEod = 0, recEof = 0, recEor = 0, scanSeekDone = 0, restoreDone = 0;
  logic [3:0] evt = 4'h0;
  logic [1:0] ioFunc;
  logic [15:0] hostWord, hostReply, wrWord, seqWord = 16'h0000, w;
  logic [15:0] expQ[$], mskQ[$], evtBits[4] = '{16'h2000, 16'h0800, 16'h0200, 16'h0200};
  int error_cnt = 0, compares = 0, cycles = 0, siCnt = 0, base;
  initial forever #12.5 mclk = ~mclk;
  host_port_model u_host_port_model (.mclk(mclk), .ioStrobe(ioStrobe), .ioFunc(ioFunc),
    .hostWord(hostWord));
  disc_ctrl_status_word u_disc_ctrl_status_word (.mclk(mclk), .rst_n(rstN), .ioStrobe(ioStrobe),
    .ioFunc(ioFunc), .hostWord(hostWord), .hostReply(hostReply), .hostReplyValid(hostReplyValid),
    .siRequest(siRequest), .dmpMode(dmpMode), .seqBusy(seqBusy), .seqTake(1'b0), .seqPut(seqPut),
    .seqWord(seqWord), .wrWord(wrWord), .wrValid(wrValid), .cmdPulse(), .cmdWord(),
    .xferEnable(), .writeEnable(), .xferStop(), .zeroFill(), .driveInop(driveInop),
    .driveSeeking(driveSeeking), .writeProtect(writeProtect), .crcErr(evt[0]),
    .parityErr(evt[1]), .seekFail(evt[2]), .headerMismatch(evt[3]), .recordEnd(recordEnd),
    .recordEod(recEod), .recordEof(recEof), .recordEor(recEor), .scanSeekDone(scanSeekDone),
    .restoreDone(restoreDone));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // Note the expected reply, then ask for it
  task automatic read_word(input logic [1:0] fn, input logic [15:0] exp, input logic [15:0] m);
    expQ.push_back(exp);
    mskQ.push_back(m);
    u_host_port_model.issue(fn, 16'h0000);
    repeat (2) @(posedge mclk);
  endtask : read_word
  task automatic cmd(input logic [15:0] word);
    u_host_port_model.issue(disc_pkg::FN_OUT_CMD, word);
    repeat (2) @(posedge mclk);
  endtask : cmd
  // Reply watcher: oldest note against each reply; also counts interrupts
  always @(posedge mclk) begin
    cycles++;
    if (siRequest === 1'b1) siCnt++;
    if (hostReplyValid === 1'b1 && expQ.size() == 0) begin
      error_cnt++;
      $display("BAD reply expected none seen %h", hostReply);
    end else if (hostReplyValid === 1'b1) begin
      check("reply", expQ[0] & mskQ[0], hostReply & mskQ[0]);
      void'(expQ.pop_front());
      void'(mskQ.pop_front());
    end
    if (cycles == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(32'h87C7));
    repeat (12) @(posedge mclk);
    rstN <= 1'b1;
    repeat (3) @(posedge mclk);
    read_word(disc_pkg::FN_IN_STATUS, 16'h8000, 16'hFF7F);
    for (int u = 0; u < 4; u++) begin
      cmd({2'b00, 12'($urandom), 2'(u)});
      read_word(disc_pkg::FN_IN_STATUS, 16'h8000 | 16'(u), 16'hFF7F);
    end
    $display("test select done");
    driveInop <= 1'b1;
    read_word(disc_pkg::FN_IN_STATUS, 16'h1000, MSK);
    driveSeeking <= 1'b1;
    read_word(disc_pkg::FN_IN_STATUS, 16'h8008, MSK);
    {driveInop, driveSeeking, writeProtect} <= 3'b001;
    read_word(disc_pkg::FN_IN_STATUS, 16'h8400, MSK);
    writeProtect <= 1'b0;
    $display("test live bits done");
    dmpMode <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      // CRC only counts inside a read, so open one first
      if (i == 0) cmd(16'h8800);
      @(posedge mclk);
      if (i < 4) evt[i] <= 1'b1;
      else u_host_port_model.issue(disc_pkg::FN_OUT_CMD, CYL | 16'h00CB);
      @(posedge mclk);
      evt <= 4'h0;
      repeat (2) @(posedge mclk);
      read_word(disc_pkg::FN_IN_STATUS, i < 4 ? evtBits[i] : 16'h0200, MSK);
      cmd(IDLE);
      read_word(disc_pkg::FN_IN_STATUS, i > 1 ? 16'h0200 : 16'h8000, MSK);
      cmd(CYL | 16'h00FF);
      restoreDone <= 1'b1;
      @(posedge mclk);
      restoreDone <= 1'b0;
      read_word(disc_pkg::FN_IN_STATUS, 16'h8000, MSK);
    end
    u_host_port_model.issue(disc_pkg::FN_IN_DATA, 16'h0000);
    dmpMode <= 1'b0;
    $display("test error flags done");
    w = 16'($urandom);
    u_host_port_model.issue(disc_pkg::FN_OUT_DATA, w);
    @(posedge mclk);
    check("write word", w, wrWord);
    check("write held", 16'h0001, {15'h0000, wrValid});
    seqWord <= 16'($urandom);
    seqPut <= 1'b1;
    @(posedge mclk);
    seqPut <= 1'b0;
    read_word(disc_pkg::FN_IN_DATA, seqWord, 16'hFFFF);
    // Record markers only land during a read: end the stopped one, start anew
    cmd(16'h4800);
    cmd(16'h8800);
    {recordEnd, recEod, recEof, recEor} <= 4'hF;
    @(posedge mclk);
    recordEnd <= 1'b0;
    repeat (2) @(posedge mclk);
    read_word(disc_pkg::FN_IN_STATUS, 16'h8070, MSK);
    cmd(IDLE);
    read_word(disc_pkg::FN_IN_STATUS, 16'h8000, MSK);
    $display("test data and record done");
    for (int c = 1; c >= 0; c--) begin
      cmd(IDLE | (c ? 16'h1000 : 16'h0000));
      base = siCnt;
      seqBusy <= 1'b1;
      repeat (2) @(posedge mclk);
      cmd(16'h8800);
      read_word(disc_pkg::FN_IN_STATUS, 16'h8100, MSK);
      seqBusy <= 1'b0;
      repeat (6) @(posedge mclk);
      check("busy fall interrupts", 16'(c), 16'(siCnt - base));
      scanSeekDone <= 1'b1;
      @(posedge mclk);
      scanSeekDone <= 1'b0;
      repeat (4) @(posedge mclk);
      read_word(disc_pkg::FN_IN_STATUS, c ? 16'h8004 : 16'h8000, MSK);
      check("all interrupts", 16'(2 * c), 16'(siCnt - base));
    end
    $display("test service interrupt done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
